// ### csf_pkg.sv
package csf_pkg;
    // =========================================================
    // register map (apb byte addresses)
    localparam logic [7:0] CSF_ADDR_FLAGS    = 8'h00;
    localparam logic [7:0] CSF_ADDR_OPERAND  = 8'h04;
    localparam logic [7:0] CSF_ADDR_RESULT   = 8'h08;
    // =========================================================
    // field positions of the status register
    localparam int CSF_BIT_CARRY  = 0;
    localparam int CSF_BIT_NIBBLE = 1;
    localparam int CSF_BIT_ZERO   = 2;
    localparam int CSF_BIT_PWRDN  = 3;
    localparam int CSF_BIT_WDEXP  = 4;
    localparam int CSF_BIT_BANK   = 5;
    localparam int CSF_BIT_RSVH   = 6;
    localparam int CSF_BIT_RSVI   = 7;
    // power-on value: expiry and powerdown set, rest zero
    localparam logic [7:0] CSF_FLAGS_RESET   = 8'h18;
    // writable by ordinary moves: bank bit and two reserved bits
    localparam logic [7:0] CSF_WR_MASK       = 8'hE0;
    localparam logic [7:0] CSF_ARITH_MASK    = 8'h07;
    localparam logic [7:0] CSF_LOWER_BANK    = 8'h00;
    localparam logic [7:0] CSF_UPPER_BANK    = 8'h80;
    // =========================================================
    // operations of the datapath
    typedef enum logic [3:0] {
        CSF_OP_MOVE   = 4'h0,
        CSF_OP_ADD    = 4'h1,
        CSF_OP_SUB    = 4'h2,
        CSF_OP_AND    = 4'h3,
        CSF_OP_OR     = 4'h4,
        CSF_OP_XOR    = 4'h5,
        CSF_OP_CLEAR  = 4'h6,
        CSF_OP_RRIGHT = 4'h7,
        CSF_OP_RLEFT  = 4'h8,
        CSF_OP_SWAP   = 4'h9,
        CSF_OP_BCLR   = 4'hA,
        CSF_OP_BSET   = 4'hB
    } csf_op_t;
endpackage : csf_pkg

// ### csf_alu.sv
`timescale 1ns/1ps
`default_nettype none
module csf_alu
    import csf_pkg::*;
(
    input  wire logic [3:0] op_in,
    input  wire logic [7:0] a_in,
    input  wire logic [7:0] b_in,
    input  wire logic [2:0] bit_in,
    input  wire logic       carry_in,
    output logic [7:0]      result_out,
    output logic            carry_out,
    output logic            nibble_out,
    output logic            touch_z_out,
    output logic            touch_c_out,
    output logic            touch_dc_out
);
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] addend;
    always_comb begin
        // subtract adds the two's complement, so carry reads as not-borrow
        addend = (op_in == CSF_OP_SUB) ? ~b_in : b_in;
        sum    = {1'b0, a_in} + {1'b0, addend} + {8'h00, op_in == CSF_OP_SUB};
        low    = {1'b0, a_in[3:0]} + {1'b0, addend[3:0]} + {4'h0, op_in == CSF_OP_SUB};
        result_out   = a_in;
        carry_out    = carry_in;
        nibble_out   = low[4];
        touch_z_out  = 1'b0;
        touch_c_out  = 1'b0;
        touch_dc_out = 1'b0;
        unique case (op_in)
            CSF_OP_ADD, CSF_OP_SUB: begin
                result_out   = sum[7:0];
                carry_out    = sum[8];
                touch_z_out  = 1'b1;
                touch_c_out  = 1'b1;
                touch_dc_out = 1'b1;
            end
            CSF_OP_AND:   begin result_out = a_in & b_in; touch_z_out = 1'b1; end
            CSF_OP_OR:    begin result_out = a_in | b_in; touch_z_out = 1'b1; end
            CSF_OP_XOR:   begin result_out = a_in ^ b_in; touch_z_out = 1'b1; end
            CSF_OP_CLEAR: begin result_out = 8'h00; touch_z_out = 1'b1; end
            CSF_OP_RRIGHT: begin
                result_out  = {carry_in, a_in[7:1]};
                carry_out   = a_in[0];
                touch_c_out = 1'b1;
            end
            CSF_OP_RLEFT: begin
                result_out  = {a_in[6:0], carry_in};
                carry_out   = a_in[7];
                touch_c_out = 1'b1;
            end
            CSF_OP_SWAP: result_out = {a_in[3:0], a_in[7:4]};
            CSF_OP_BCLR: result_out = a_in & ~(8'h01 << bit_in);
            CSF_OP_BSET: result_out = a_in | (8'h01 << bit_in);
            default:     result_out = b_in;
        endcase
    end
endmodule : csf_alu
`default_nettype wire

// ### csf_core_flags.sv
`timescale 1ns/1ps
`default_nettype none
module csf_core_flags
    import csf_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        exec_valid_in,
    input  wire logic [3:0]  exec_op_in,
    input  wire logic [7:0]  exec_file_in,
    input  wire logic [7:0]  exec_w_in,
    input  wire logic [2:0]  exec_bit_in,
    input  wire logic        exec_to_status_in,
    input  wire logic        watchdog_clear_instr_in,
    input  wire logic        sleep_instr_in,
    input  wire logic        watchdog_timeout_in,
    output logic [7:0]       exec_result_out,
    output logic [7:0]       bank_base_out,
    output logic [7:0]       flags_out
);
    import csf_pkg::*;

    // =========================================================
    // pin synchronisers for the watchdog side
    logic [1:0] wd_sync_reg, wd_sync_next;
    logic [1:0] sl_sync_reg, sl_sync_next;
    logic [1:0] to_sync_reg, to_sync_next;
    always_comb begin
        wd_sync_next = {wd_sync_reg[0], watchdog_clear_instr_in};
        sl_sync_next = {sl_sync_reg[0], sleep_instr_in};
        to_sync_next = {to_sync_reg[0], watchdog_timeout_in};
    end
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wd_sync_reg <= 2'h0;
            sl_sync_reg <= 2'h0;
            to_sync_reg <= 2'h0;
        end else begin
            wd_sync_reg <= wd_sync_next;
            sl_sync_reg <= sl_sync_next;
            to_sync_reg <= to_sync_next;
        end
    end
    logic wd_clr, sleep_ev, tmo_ev;
    assign wd_clr   = wd_sync_reg[1];
    assign sleep_ev = sl_sync_reg[1];
    assign tmo_ev   = to_sync_reg[1];

    // =========================================================
    // datapath
    logic [7:0] alu_res;
    logic       alu_c, alu_dc, t_z, t_c, t_dc;
    logic [7:0] flags_reg, flags_next;
    csf_alu u_alu (
        .op_in        (exec_op_in),
        .a_in         (exec_file_in),
        .b_in         (exec_w_in),
        .bit_in       (exec_bit_in),
        .carry_in     (flags_reg[CSF_BIT_CARRY]),
        .result_out   (alu_res),
        .carry_out    (alu_c),
        .nibble_out   (alu_dc),
        .touch_z_out  (t_z),
        .touch_c_out  (t_c),
        .touch_dc_out (t_dc)
    );

    // =========================================================
    // apb slave, zero wait states
    logic        apb_wr, apb_rd;
    logic [7:0]  oper_reg, oper_next;
    logic [7:0]  res_reg, res_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        err_reg, err_next;
    logic        bad_addr;
    always_comb begin
        apb_wr   = psel_in && penable_in && pwrite_in;
        apb_rd   = psel_in && !penable_in && !pwrite_in;
        bad_addr = !(paddr_in == CSF_ADDR_FLAGS || paddr_in == CSF_ADDR_OPERAND
                     || paddr_in == CSF_ADDR_RESULT);
        oper_next = oper_reg;
        if (apb_wr && paddr_in == CSF_ADDR_OPERAND) begin
            oper_next = pwdata_in[7:0];
        end
        res_next = exec_valid_in ? alu_res : res_reg;
        rdata_next = rdata_reg;
        if (apb_rd) begin
            unique case (1'b1)
                paddr_in == CSF_ADDR_FLAGS:   rdata_next = {24'h000000, flags_reg};
                paddr_in == CSF_ADDR_OPERAND: rdata_next = {24'h000000, oper_reg};
                paddr_in == CSF_ADDR_RESULT:  rdata_next = {24'h000000, res_reg};
                default:                      rdata_next = 32'h00000000;
            endcase
        end
        err_next = psel_in && !penable_in && bad_addr;
    end

    // =========================================================
    // status register next value
    logic [7:0] wr_val;
    logic       wr_en;
    always_comb begin
        flags_next = flags_reg;
        wr_en  = 1'b0;
        wr_val = 8'h00;
        // software writes act as a move to the status register
        if (apb_wr && paddr_in == CSF_ADDR_FLAGS) begin
            wr_en  = 1'b1;
            wr_val = pwdata_in[7:0];
        end else if (exec_valid_in && exec_to_status_in) begin
            wr_en  = 1'b1;
            wr_val = alu_res;
        end
        if (wr_en) begin
            // expiry and powerdown never come from the written value
            flags_next = (flags_next & ~CSF_WR_MASK) | (wr_val & CSF_WR_MASK);
            // only a bus write to status itself may override the flag-write block
            if (!(exec_valid_in && (t_z || t_c || t_dc)) || (apb_wr && paddr_in == CSF_ADDR_FLAGS)) begin
                flags_next[2:0] = wr_val[2:0];
            end
        end
        // computed flags override the write in the same instruction
        if (exec_valid_in && !(apb_wr && paddr_in == CSF_ADDR_FLAGS)) begin
            if (t_z) flags_next[CSF_BIT_ZERO] = (alu_res == 8'h00);
            if (t_c) flags_next[CSF_BIT_CARRY] = alu_c;
            if (t_dc) flags_next[CSF_BIT_NIBBLE] = alu_dc;
        end
        // hardware events; set wins over time-out clear
        if (tmo_ev) flags_next[CSF_BIT_WDEXP] = 1'b0;
        if (sleep_ev) begin
            flags_next[CSF_BIT_WDEXP] = 1'b1;
            flags_next[CSF_BIT_PWRDN] = 1'b0;
        end
        if (wd_clr) begin
            flags_next[CSF_BIT_WDEXP] = 1'b1;
            flags_next[CSF_BIT_PWRDN] = 1'b1;
        end
    end

    // =========================================================
    // registers
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flags_reg       <= CSF_FLAGS_RESET;
            oper_reg        <= 8'h00;
            res_reg         <= 8'h00;
            rdata_reg       <= 32'h00000000;
            err_reg         <= 1'b0;
            exec_result_out <= 8'h00;
            bank_base_out   <= CSF_LOWER_BANK;
            flags_out       <= CSF_FLAGS_RESET;
        end else begin
            flags_reg       <= flags_next;
            oper_reg        <= oper_next;
            res_reg         <= res_next;
            rdata_reg       <= rdata_next;
            err_reg         <= err_next;
            exec_result_out <= res_next;
            bank_base_out   <= flags_next[CSF_BIT_BANK] ? CSF_UPPER_BANK : CSF_LOWER_BANK;
            flags_out       <= flags_next;
        end
    end
    assign prdata_out  = rdata_reg;
    assign pslverr_out = err_reg;
    assign pready_out  = 1'b1;

    // =========================================================
    // checks
    wdclr_sets_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wd_clr |=> flags_reg[CSF_BIT_WDEXP] && flags_reg[CSF_BIT_PWRDN])
        else $error("watchdog clear did not set expiry and powerdown");
    sleep_flags_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        sleep_ev && !wd_clr |=> flags_reg[CSF_BIT_WDEXP] && !flags_reg[CSF_BIT_PWRDN])
        else $error("sleep flags wrong");
    timeout_clear_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        tmo_ev && !sleep_ev && !wd_clr |=> !flags_reg[CSF_BIT_WDEXP])
        else $error("time-out did not clear expiry");
    hw_only_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !tmo_ev && !sleep_ev && !wd_clr |=> $stable(flags_reg[4:3]))
        else $error("expiry or powerdown changed by write");
    zero_flag_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        exec_valid_in && t_z && !(apb_wr && paddr_in == CSF_ADDR_FLAGS)
        |=> flags_reg[CSF_BIT_ZERO] == ($past(alu_res) == 8'h00))
        else $error("zero flag wrong");
    add_carry_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        exec_valid_in && exec_op_in == CSF_OP_ADD && !(apb_wr && paddr_in == CSF_ADDR_FLAGS)
        |=> flags_reg[CSF_BIT_CARRY] == $past(({1'b0, exec_file_in} + {1'b0, exec_w_in}) > 9'h0FF))
        else $error("add carry wrong");
    sub_borrow_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        exec_valid_in && exec_op_in == CSF_OP_SUB && !(apb_wr && paddr_in == CSF_ADDR_FLAGS)
        |=> flags_reg[CSF_BIT_CARRY] == $past(exec_w_in <= exec_file_in)
            && flags_reg[CSF_BIT_NIBBLE] == $past(exec_w_in[3:0] <= exec_file_in[3:0]))
        else $error("subtract borrow wrong");
    rotate_carry_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        exec_valid_in && exec_op_in == CSF_OP_RRIGHT && !(apb_wr && paddr_in == CSF_ADDR_FLAGS)
        |=> flags_reg[CSF_BIT_CARRY] == $past(exec_file_in[0]))
        else $error("rotate carry wrong");
    bank_out_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
        bank_base_out == (flags_reg[CSF_BIT_BANK] ? CSF_UPPER_BANK : CSF_LOWER_BANK))
        else $error("bank base mismatch");
endmodule : csf_core_flags
`default_nettype wire

// ### csf_exec_model.sv
`timescale 1ns/1ps
`default_nettype none
// =========================================================
// execution datapath and watchdog/sleep side of the flags
module csf_exec_model (
    input  wire logic       clk_in,
    output logic            exec_valid_out,
    output logic [3:0]      exec_op_out,
    output logic [7:0]      exec_file_out,
    output logic [7:0]      exec_w_out,
    output logic [2:0]      exec_bit_out,
    output logic            exec_to_status_out,
    output logic            wd_clear_out,
    output logic            sleep_out,
    output logic            timeout_out
);
    import csf_pkg::*;
    initial begin
        exec_valid_out = 1'b0;
        exec_op_out = 4'h0;
        exec_file_out = 8'h00;
        exec_w_out = 8'h00;
        exec_bit_out = 3'h0;
        exec_to_status_out = 1'b0;
        wd_clear_out = 1'b0;
        sleep_out = 1'b0;
        timeout_out = 1'b0;
    end
    // =========================================================
    // one instruction, reserved bits kept clear by the callers
    task automatic run(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b,
                       input logic [2:0] bn, input logic st);
        @(posedge clk_in);
        exec_valid_out <= 1'b1;
        exec_op_out <= op;
        exec_file_out <= a;
        exec_w_out <= b;
        exec_bit_out <= bn;
        exec_to_status_out <= st;
        @(posedge clk_in);
        exec_valid_out <= 1'b0;
        // operands no longer valid: show garbage, not the last value
        exec_file_out <= ~a;
        exec_w_out <= ~b;
        exec_to_status_out <= ~st;
    endtask : run
    // =========================================================
    // one-cycle event: 0 watchdog clear, 1 sleep, 2 time-out
    task automatic pulse(input logic [1:0] which);
        @(posedge clk_in);
        wd_clear_out <= (which == 2'h0);
        sleep_out <= (which == 2'h1);
        timeout_out <= (which == 2'h2);
        @(posedge clk_in);
        wd_clear_out <= 1'b0;
        sleep_out <= 1'b0;
        timeout_out <= 1'b0;
    endtask : pulse
endmodule : csf_exec_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
    import csf_pkg::*;
    logic        clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic        ev, eto, wdc, slp, tmo;
    logic [3:0]  eop;
    logic [7:0]  efile, ew, exec_result_out, bank_base_out, flags_out;
    logic [2:0]  ebit;
    logic [31:0] rd;
    logic        er;
    int          err_total = 0;
    int          comparisons = 0;
    always #2 clk_in = ~clk_in;
    csf_core_flags u_csf_core_flags (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .exec_valid_in(ev), .exec_op_in(eop),
        .exec_file_in(efile), .exec_w_in(ew), .exec_bit_in(ebit), .exec_to_status_in(eto),
        .watchdog_clear_instr_in(wdc), .sleep_instr_in(slp), .watchdog_timeout_in(tmo),
        .exec_result_out(exec_result_out), .bank_base_out(bank_base_out), .flags_out(flags_out));
    csf_exec_model u_csf_exec_model (.clk_in(clk_in), .exec_valid_out(ev), .exec_op_out(eop),
        .exec_file_out(efile), .exec_w_out(ew), .exec_bit_out(ebit), .exec_to_status_out(eto),
        .wd_clear_out(wdc), .sleep_out(slp), .timeout_out(tmo));
    // =========================================================
    // bus and compare helpers
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        if (n >= 50) err_total++;
        rd = prdata_out;
        er = pslverr_out;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~wd;
    endtask : apb
    task automatic st(input logic [7:0] f);
        #1;
        `CHK("flags", f, flags_out)
        `CHK("bank base", (f[5] ? CSF_UPPER_BANK : CSF_LOWER_BANK), bank_base_out)
    endtask : st
    task automatic ev_chk(input logic [1:0] which, input logic [7:0] f);
        u_csf_exec_model.pulse(which);
        repeat (3) @(posedge clk_in);
        st(f);
    endtask : ev_chk
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    // =========================================================
    // scenarios
    task automatic t_bus();
        st(CSF_FLAGS_RESET);
        apb(1'b0, CSF_ADDR_FLAGS, 32'h0);
        `CHK("read status", 32'h00000018, rd)
        apb(1'b0, 8'h0C, 32'h0);
        `CHK("unmapped err", 1'b1, er)
        `CHK("unmapped data", 32'h0, rd)
        apb(1'b1, CSF_ADDR_FLAGS, 32'h00000027);
        st(8'h3F);
        apb(1'b0, CSF_ADDR_FLAGS, 32'h0);
        `CHK("read back", 32'h0000003F, rd)
        apb(1'b1, CSF_ADDR_FLAGS, 32'h00000000);
        st(8'h18);
    endtask : t_bus
    task automatic t_arith();
        logic [39:0] tbl [15] = '{40'h1_0F_01_0_10_1A, 40'h1_FF_01_0_00_1F, 40'h2_10_01_0_0F_19,
            40'h2_01_02_0_FF_18, 40'h2_05_05_0_00_1F, 40'h3_F0_FF_0_F0_1B, 40'h4_12_01_0_13_1B,
            40'h6_00_00_0_00_1F, 40'h0_00_00_0_00_1F, 40'h5_55_AA_0_FF_1B, 40'h7_02_02_0_81_1A,
            40'h8_80_80_0_00_1B, 40'h9_3C_3C_0_C3_1B, 40'hB_00_00_3_08_1B, 40'hA_FF_FF_0_FE_1B};
        foreach (tbl[i]) begin
            u_csf_exec_model.run(tbl[i][39:36], tbl[i][35:28], tbl[i][27:20], tbl[i][18:16], 1'b0);
            st(tbl[i][7:0]);
            `CHK("result", tbl[i][15:8], exec_result_out)
        end
    endtask : t_arith
    task automatic t_status_dest();
        apb(1'b1, CSF_ADDR_FLAGS, 32'h00000020);
        st(8'h38);
        u_csf_exec_model.run(CSF_OP_CLEAR, 8'h00, 8'h00, 3'h0, 1'b1);
        st(8'h1C);
        u_csf_exec_model.run(CSF_OP_ADD, 8'h1F, 8'h01, 3'h0, 1'b1);
        st(8'h3A);
        ev_chk(2'h2, 8'h2A);
        u_csf_exec_model.run(CSF_OP_MOVE, 8'h38, 8'h38, 3'h0, 1'b1);
        st(8'h28);
        apb(1'b1, CSF_ADDR_FLAGS, 32'h00000038);
        st(8'h28);
        ev_chk(2'h1, 8'h30);
        ev_chk(2'h0, 8'h38);
        apb(1'b0, CSF_ADDR_RESULT, 32'h0);
        `CHK("result reg", 32'h00000038, rd)
    endtask : t_status_dest
    // =========================================================
    // main sequence and watchdog
    initial begin
        repeat (12) @(posedge clk_in);
        nrst_in <= 1'b1;
        t_bus();
        t_arith();
        t_status_dest();
        results();
    end
    initial begin
        #20000;
        err_total++;
        results();
    end
endmodule : tb_top
`default_nettype wire
